// >>> core/mirq_defines.vh
// constants for the modem interrupt and lock-loss abort block
// assumes a single 10 MHz modem clock and a same-clock register port
// Behaviour
// - lock detector reports unlock: set unlock flag, status bit 15 at 0x24
// - unlock aborts any running assessment, receive or transmit operation
// - after that abort the sequencer returns straight to idle and waits
// - unlock drives the request pin only when mask bit 9 at 0x05 is set
// - while unlock flag is set, new operations abort at once; host clears first
// - an aborted operation sets no completion flag and raises no request
// - enabled event sets its flag and pulls the active-low request pin low
// - pin stays low until status read, or until a mask write disables every set flag; that read clears all flags except any set in the same cycle
`ifndef MIRQ_DEFINES_VH
`define MIRQ_DEFINES_VH

`define MIRQ_ADDR_W 6
`define MIRQ_DATA_W 16
`define MIRQ_ADDR_MASK 6'h05
`define MIRQ_ADDR_STATUS 6'h24
`define MIRQ_MASK_RESET 16'h0000
`define MIRQ_STATUS_RESET 16'h0000

// status bit positions
`define MIRQ_ST_PLL 15
`define MIRQ_ST_RX_DONE 3
`define MIRQ_ST_TX_DONE 2
`define MIRQ_ST_CCA_DONE 5
`define MIRQ_ST_CCA_BUSY 1

// mask bit positions
`define MIRQ_MK_PLL 9
`define MIRQ_MK_RX_DONE 3
`define MIRQ_MK_TX_DONE 2
`define MIRQ_MK_CCA_DONE 10

// operation codes
`define MIRQ_OP_CCA 2'h1
`define MIRQ_OP_RX 2'h2
`define MIRQ_OP_TX 2'h3
`define MIRQ_OP_NONE 2'h0

// read data after reset and for unmapped addresses
`define MIRQ_RDATA_IDLE 16'h0000

`endif

// >>> core/mirq_sync.v
// three-stage synchroniser with agreement filter for the lock detector level
// assumes the input is asynchronous to clk_i
`timescale 1ns/1ps
module mirq_sync (
  input wire clk_i,
  input wire reset_n_i,
  input wire async_i,
  output reg level_o
);
  reg stage1;
  reg stage2;
  reg stage3;

  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level_o <= 1'b0;
    end else begin
      stage1 <= async_i;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        level_o <= stage3;
      end
    end
  end
endmodule // mirq_sync

// >>> core/mirq_ctrl.v
// modem interrupt flags, request pin and lock-loss abort of the sequencer
// assumes host register access on a same-clock read/write port
`timescale 1ns/1ps
`include "mirq_defines.vh"
module mirq_ctrl (
  input wire clk_i,
  input wire reset_n_i,
  input wire pll_unlock_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [`MIRQ_ADDR_W-1:0] reg_addr_i,
  input wire [`MIRQ_DATA_W-1:0] reg_wdata_i,
  input wire op_start_i,
  input wire [1:0] op_type_i,
  input wire op_done_i,
  input wire cca_busy_i,
  output reg [`MIRQ_DATA_W-1:0] reg_rdata_o,
  output reg irq_n_o,
  output reg seq_busy_o,
  output reg [1:0] seq_op_o,
  output reg seq_abort_o
);
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  reg [`MIRQ_DATA_W-1:0] event_mask_reg;
  reg [`MIRQ_DATA_W-1:0] event_status_reg;
  reg state;
  reg [1:0] cur_op;
  reg unlock_prev;
  wire unlock_lvl;

  reg [`MIRQ_DATA_W-1:0] next_status;
  reg [`MIRQ_DATA_W-1:0] set_vec;
  reg next_state;
  reg [1:0] next_op;
  reg next_abort;
  reg next_irq_n;

  wire status_rd;
  wire mask_rd;
  wire mask_wr;
  wire unlock_evt;
  wire unlock_held;
  wire unlock_block;
  wire op_idle;
  wire op_accepted;
  wire op_refused;
  wire op_lost;
  wire op_finished;
  wire [`MIRQ_DATA_W-1:0] irq_enable;
  reg next_busy;
  reg [`MIRQ_DATA_W-1:0] next_mask;
  reg [`MIRQ_DATA_W-1:0] next_rdata;

  // expands mask bits onto status bit positions
  function [`MIRQ_DATA_W-1:0] mask_to_status;
    input [`MIRQ_DATA_W-1:0] m;
    begin
      mask_to_status = {`MIRQ_DATA_W{1'b0}};
      mask_to_status[`MIRQ_ST_PLL] = m[`MIRQ_MK_PLL];
      mask_to_status[`MIRQ_ST_RX_DONE] = m[`MIRQ_MK_RX_DONE];
      mask_to_status[`MIRQ_ST_TX_DONE] = m[`MIRQ_MK_TX_DONE];
      mask_to_status[`MIRQ_ST_CCA_DONE] = m[`MIRQ_MK_CCA_DONE];
    end
  endfunction

  // address compare used by every register decode
  function hit;
    input [`MIRQ_ADDR_W-1:0] a;
    input [`MIRQ_ADDR_W-1:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // completion flags of one normally finished operation
  function [`MIRQ_DATA_W-1:0] done_flags;
    input [1:0] op;
    input busy;
    begin
      done_flags = {`MIRQ_DATA_W{1'b0}};
      case (op)
        `MIRQ_OP_CCA: begin
          done_flags[`MIRQ_ST_CCA_DONE] = 1'b1;
          done_flags[`MIRQ_ST_CCA_BUSY] = busy;
        end
        `MIRQ_OP_RX: begin
          done_flags[`MIRQ_ST_RX_DONE] = 1'b1;
        end
        `MIRQ_OP_TX: begin
          done_flags[`MIRQ_ST_TX_DONE] = 1'b1;
        end
        default: begin
          done_flags = {`MIRQ_DATA_W{1'b0}};
        end
      endcase
    end
  endfunction

  mirq_sync u_lock_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i(pll_unlock_i),
    .level_o(unlock_lvl)
  );

  assign status_rd = reg_rd_i & hit(reg_addr_i, `MIRQ_ADDR_STATUS);
  assign mask_rd = reg_rd_i & hit(reg_addr_i, `MIRQ_ADDR_MASK);
  assign mask_wr = reg_wr_i & hit(reg_addr_i, `MIRQ_ADDR_MASK);
  assign unlock_evt = unlock_lvl & ~unlock_prev;
  assign unlock_held = event_status_reg[`MIRQ_ST_PLL];
  assign unlock_block = unlock_held | unlock_evt;
  assign irq_enable = mask_to_status(event_mask_reg);
  assign op_idle = (state == ST_IDLE);
  assign op_accepted = op_idle & op_start_i & ~unlock_block;
  assign op_refused = op_idle & op_start_i & unlock_block;
  assign op_lost = (state == ST_RUN) & unlock_evt;
  assign op_finished = (state == ST_RUN) & op_done_i & ~unlock_evt;

  // sequencer next state
  always @* begin
    next_state = state;
    next_op = cur_op;
    case (state)
      ST_IDLE: begin
        if (op_accepted) begin
          next_state = ST_RUN;
          next_op = op_type_i;
        end
      end
      ST_RUN: begin
        if (op_lost | op_finished) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_busy = (next_state == ST_RUN);
    next_abort = op_lost | op_refused;
  end

  // flags raised this cycle, completion flags only on an unaborted finish
  always @* begin
    set_vec = {`MIRQ_DATA_W{1'b0}};
    set_vec[`MIRQ_ST_PLL] = unlock_evt;
    if (op_finished) begin
      set_vec = set_vec | done_flags(cur_op, cca_busy_i);
    end
  end

  // read clears all, a same-cycle set survives
  always @* begin
    if (status_rd) begin
      next_status = set_vec;
    end else begin
      next_status = event_status_reg | set_vec;
    end
    next_irq_n = ~|(next_status & irq_enable);
  end

  // register port: mask write and read data select
  always @* begin
    next_mask = event_mask_reg;
    if (mask_wr) begin
      next_mask = reg_wdata_i;
    end
    next_rdata = reg_rdata_o;
    if (status_rd) begin
      next_rdata = event_status_reg;
    end else if (mask_rd) begin
      next_rdata = event_mask_reg;
    end else if (reg_rd_i) begin
      next_rdata = `MIRQ_RDATA_IDLE;
    end
  end

  // edge detector on the filtered lock level
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      unlock_prev <= 1'b0;
    end else begin
      unlock_prev <= unlock_lvl;
    end
  end

  // mask, status and read data registers
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      event_mask_reg <= `MIRQ_MASK_RESET;
      event_status_reg <= `MIRQ_STATUS_RESET;
      reg_rdata_o <= `MIRQ_RDATA_IDLE;
    end else begin
      event_mask_reg <= next_mask;
      event_status_reg <= next_status;
      reg_rdata_o <= next_rdata;
    end
  end

  // interrupt request pin
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_n_o <= 1'b1;
    end else begin
      irq_n_o <= next_irq_n;
    end
  end

  // sequencer state and outputs
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ST_IDLE;
      cur_op <= `MIRQ_OP_NONE;
      seq_busy_o <= 1'b0;
      seq_op_o <= `MIRQ_OP_NONE;
      seq_abort_o <= 1'b0;
    end else begin
      state <= next_state;
      cur_op <= next_op;
      seq_busy_o <= next_busy;
      seq_op_o <= next_op;
      seq_abort_o <= next_abort;
    end
  end
endmodule // mirq_ctrl

// >>> testbench/mirq_seq_model.sv
// partner sequencer: ends a running operation after a fixed span
// assumes busy_i is the block's busy output
`timescale 1ns/1ps
module mirq_seq_model (
  input wire clk_i,
  input wire busy_i,
  output reg done_o = 1'h0
);
  reg [4:0] cnt = 5'h00;
  always @(posedge clk_i) begin
    cnt <= #1 busy_i ? cnt + 5'h01 : 5'h00;
    done_o <= #1 busy_i && cnt == 5'h13;
  end
endmodule // mirq_seq_model

// >>> testbench/mirq_ctrl_properties.sv
// port checker for mirq_ctrl
// bound into each mirq_ctrl
`timescale 1ns/1ps
`include "mirq_defines.vh"
module mirq_props (
  input wire clk_i,
  input wire reset_n_i,
  input wire pll_unlock_i,
  input wire reg_rd_i,
  input wire [`MIRQ_ADDR_W-1:0] reg_addr_i,
  input wire op_start_i,
  input wire op_done_i,
  input wire irq_n_o,
  input wire seq_busy_o,
  input wire seq_abort_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence lost; $rose(pll_unlock_i) && seq_busy_o; endsequence
  sequence quit; seq_abort_o && !seq_busy_o; endsequence
  a_lock_abort: assert property (lost |-> ##[2:8] quit)
    else $error("abort late");
  a_abort_idle: assert property (seq_abort_o |-> !seq_busy_o)
    else $error("busy on abort");
  a_start_answer: assert property (op_start_i && !seq_busy_o |=> seq_busy_o or quit)
    else $error("start lost");
  a_irq_hold: assert property
    (!irq_n_o && !(reg_rd_i && reg_addr_i == `MIRQ_ADDR_STATUS) |=> !irq_n_o)
    else $error("irq released");
  a_done_idle: assert property (seq_busy_o && op_done_i |=> !seq_busy_o)
    else $error("busy after done");
  a_busy_hold: assert property (seq_busy_o && !op_done_i |=> seq_busy_o or quit)
    else $error("busy dropped");
  a_idle_stay: assert property (!seq_busy_o && !op_start_i |=> !seq_busy_o)
    else $error("busy unasked");
  a_abort_once: assert property (seq_abort_o && !op_start_i |=> !seq_abort_o)
    else $error("abort held");
endmodule // mirq_props
bind mirq_ctrl mirq_props mirq_props_i (.*);

// >>> testbench/mirq_ctrl_tb.sv
// bench for mirq_ctrl
// assumes mirq_seq_model ends each operation
`timescale 1ns/1ps
`include "mirq_defines.vh"
module mirq_ctrl_tb;
  reg clk_i = 0, reset_n_i = 0, pll_unlock_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  reg op_start_i = 0, cca_busy_i = 0;
  reg [5:0] reg_addr_i = 0;
  reg [15:0] reg_wdata_i = 0;
  reg [1:0] op_type_i = 0;
  wire op_done_i, irq_n_o, seq_busy_o, seq_abort_o;
  wire [15:0] reg_rdata_o;
  wire [1:0] seq_op_o;
  integer errors = 0, checks = 0;
  always #50 clk_i = ~clk_i;
  mirq_ctrl mirq_ctrl_i (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pll_unlock_i(pll_unlock_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .op_start_i(op_start_i),
    .op_type_i(op_type_i),
    .op_done_i(op_done_i),
    .cca_busy_i(cca_busy_i),
    .reg_rdata_o(reg_rdata_o),
    .irq_n_o(irq_n_o),
    .seq_busy_o(seq_busy_o),
    .seq_op_o(seq_op_o),
    .seq_abort_o(seq_abort_o)
  );
  mirq_seq_model mirq_seq_model_i (.clk_i(clk_i), .busy_i(seq_busy_o), .done_o(op_done_i));
  task cmp(input [8*5:1] n, input [15:0] e, input [15:0] g);
    checks = checks + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("wrong value %0s exp %h got %h", n, e, g);
    end
  endtask
  task st(input integer k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task acc(input w, input [5:0] a, input [15:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = w;
    reg_rd_i = !w;
    st(1);
    reg_wr_i = 0;
    reg_rd_i = 0;
    if (!w) cmp("data", d, reg_rdata_o);
    st(1);
  endtask
  task op(input [1:0] t);
    op_type_i = t;
    op_start_i = 1;
    st(1);
    op_start_i = 0;
  endtask
  task lose(input [1:0] t);
    op(t);
    pll_unlock_i = 1;
    repeat (12) if (seq_abort_o !== 1'h1) st(1);
    cmp("abort", 1'h1, seq_abort_o);
    cmp("busy", 1'h0, seq_busy_o);
    pll_unlock_i = 0;
    st(8);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    errors = errors + 1;
    print_verdict;
  end
  initial begin
    st(4);
    reset_n_i = 1;
    st(1);
    cmp("irq", 1'h1, irq_n_o);
    acc(1, `MIRQ_ADDR_MASK, 16'h0608);
    op(`MIRQ_OP_RX);
    cmp("seqop", `MIRQ_OP_RX, seq_op_o);
    repeat (30) if (seq_busy_o === 1'h1) st(1);
    st(1);
    cmp("irq", 1'h0, irq_n_o);
    acc(0, `MIRQ_ADDR_MASK, 16'h0608);
    cmp("irq", 1'h0, irq_n_o);
    acc(0, `MIRQ_ADDR_STATUS, 16'h0008);
    cmp("irq", 1'h1, irq_n_o);
    $display("rx test end");
    acc(1, `MIRQ_ADDR_MASK, 16'h0604);
    cca_busy_i = 1;
    op(`MIRQ_OP_CCA);
    cmp("seqop", `MIRQ_OP_CCA, seq_op_o);
    repeat (30) if (seq_busy_o === 1'h1) st(1);
    st(1);
    cmp("irq", 1'h0, irq_n_o);
    acc(0, `MIRQ_ADDR_STATUS, 16'h0022);
    cca_busy_i = 0;
    op(`MIRQ_OP_TX);
    repeat (30) if (seq_busy_o === 1'h1) st(1);
    st(1);
    cmp("irq", 1'h0, irq_n_o);
    acc(0, `MIRQ_ADDR_STATUS, 16'h0004);
    cmp("irq", 1'h1, irq_n_o);
    // the model ends an operation 21 edges after its start edge: read there
    op(`MIRQ_OP_TX);
    st(20);
    acc(0, `MIRQ_ADDR_STATUS, 16'h0000);
    cmp("irq", 1'h0, irq_n_o);
    acc(0, `MIRQ_ADDR_STATUS, 16'h0004);
    cmp("irq", 1'h1, irq_n_o);
    $display("done test end");
    acc(1, `MIRQ_ADDR_MASK, 16'h0000);
    lose(`MIRQ_OP_TX);
    cmp("irq", 1'h1, irq_n_o);
    acc(0, `MIRQ_ADDR_STATUS, 16'h8000);
    $display("masked test end");
    acc(1, `MIRQ_ADDR_MASK, 16'h0200);
    lose(`MIRQ_OP_CCA);
    cmp("irq", 1'h0, irq_n_o);
    op(`MIRQ_OP_RX);
    cmp("abort", 1'h1, seq_abort_o);
    cmp("busy", 1'h0, seq_busy_o);
    acc(0, `MIRQ_ADDR_STATUS, 16'h8000);
    cmp("irq", 1'h1, irq_n_o);
    op(`MIRQ_OP_RX);
    cmp("busy", 1'h1, seq_busy_o);
    repeat (30) if (seq_busy_o === 1'h1) st(1);
    st(1);
    cmp("irq", 1'h1, irq_n_o);
    acc(0, `MIRQ_ADDR_STATUS, 16'h0008);
    $display("held test end");
    op(`MIRQ_OP_TX);
    st(3);
    reset_n_i = 0;
    st(1);
    cmp("busy", 1'h0, seq_busy_o);
    cmp("seqop", `MIRQ_OP_NONE, seq_op_o);
    cmp("data", 16'h0000, reg_rdata_o);
    cmp("irq", 1'h1, irq_n_o);
    reset_n_i = 1;
    st(2);
    cmp("busy", 1'h0, seq_busy_o);
    acc(0, `MIRQ_ADDR_MASK, 16'h0000);
    acc(0, `MIRQ_ADDR_STATUS, 16'h0000);
    $display("reset test end");
    print_verdict;
  end
endmodule // mirq_ctrl_tb
